// *** src/ptc_params.svh ***
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH

// Per-peripheral register offsets (byte addresses inside one peripheral).
`define PTC_OFS_W 9
`define PTC_OFS_RX_PTR 9'h100
`define PTC_OFS_RX_CNT 9'h104
`define PTC_OFS_TX_PTR 9'h108
`define PTC_OFS_TX_CNT 9'h10C
`define PTC_OFS_RX_NPTR 9'h110
`define PTC_OFS_RX_NCNT 9'h114
`define PTC_OFS_TX_NPTR 9'h118
`define PTC_OFS_TX_NCNT 9'h11C
`define PTC_OFS_CTRL 9'h120
`define PTC_OFS_STAT 9'h124

// Control command bits.
`define PTC_CTRL_RX_EN 0
`define PTC_CTRL_RX_DIS 1
`define PTC_CTRL_TX_EN 8
`define PTC_CTRL_TX_DIS 9

// Status bits.
`define PTC_STAT_RX_EN 0
`define PTC_STAT_TX_EN 8
`define PTC_STAT_END_RX 16
`define PTC_STAT_END_TX 17
`define PTC_STAT_RX_FULL 18
`define PTC_STAT_TX_EMPTY 19

// Reset values and peripheral count.
`define PTC_PTR_RESET 32'h0000_0000
`define PTC_CNT_RESET 16'h0000
`define PTC_NPERIPH 2

`endif

// *** src/ptc_pkg.sv ***
package ptc_pkg;

  typedef enum logic [1:0] {PTC_BYTE, PTC_HALF, PTC_WORD} ptc_width_e;

  typedef enum logic [2:0] {
    PTC_IDLE,
    PTC_RX_READ,
    PTC_RX_WRITE,
    PTC_TX_READ,
    PTC_TX_PUSH
  } ptc_state_e;

  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] cnt;
    logic [31:0] nptr;
    logic [15:0] ncnt;
    logic en;
    logic endFlag;
    logic bothFlag;
  } ptc_chan_s;

  typedef struct packed {
    logic wrPtr;
    logic wrCnt;
    logic wrNptr;
    logic wrNcnt;
    logic enCmd;
    logic disCmd;
    logic [31:0] data;
  } ptc_chan_wr_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    ptc_width_e size;
    logic wr;
    logic rd;
  } ptc_mem_s;

endpackage : ptc_pkg

// *** src/ptc_pick.sv ***
module ptc_pick #(
  parameter int N = 2,
  parameter int IW = 1
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [IW-1:0] idx
);
  import ptc_pkg::*;

  // Lowest peripheral number wins among simultaneous requests.
  always_comb begin
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = IW'(i);
      end
    end
  end

  assign any = |req;

endmodule : ptc_pick

// *** src/ptc_channel.sv ***
`include "ptc_params.svh"

module ptc_channel (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input ptc_pkg::ptc_chan_wr_s wr,
  input wire logic step,
  input ptc_pkg::ptc_width_e width,
  output ptc_pkg::ptc_chan_s st,
  output logic trig
);
  import ptc_pkg::*;

  logic [31:0] ptr_q, ptr_d, nptr_q, nptr_d;
  logic [15:0] cnt_q, cnt_d, ncnt_q, ncnt_d;
  logic en_q, en_d, end_q, end_d, both_q, both_d;

  wire [31:0] stepInc = 32'h0000_0001 << width;
  wire [31:0] ptrNext = ptr_q + stepInc;
  wire [15:0] cntNext = cnt_q - 16'h0001;
  wire [15:0] wrCntVal = wr.data[15:0];
  wire doStep = step && (cnt_q != 16'h0000);
  wire hitZero = doStep && (cntNext == 16'h0000);
  wire chain = hitZero && (ncnt_q != 16'h0000);
  wire cntWrite = wr.wrCnt || wr.wrNcnt;

  always_comb begin
    ptr_d = ptr_q;
    if (wr.wrPtr) begin
      ptr_d = wr.data;
    end else if (chain) begin
      ptr_d = nptr_q;
    end else if (doStep) begin
      ptr_d = ptrNext;
    end
    cnt_d = cnt_q;
    if (wr.wrCnt) begin
      cnt_d = wrCntVal;
    end else if (chain) begin
      cnt_d = ncnt_q;
    end else if (doStep) begin
      cnt_d = cntNext;
    end
    nptr_d = wr.wrNptr ? wr.data : nptr_q;
    ncnt_d = ncnt_q;
    if (wr.wrNcnt) begin
      ncnt_d = wrCntVal;
    end else if (chain) begin
      ncnt_d = 16'h0000;
    end
    en_d = en_q;
    if (wr.disCmd) begin
      en_d = 1'b0;
    end else if (wr.enCmd) begin
      en_d = 1'b1;
    end
    end_d = end_q;
    if (hitZero) begin
      end_d = 1'b1;
    end else if (cntWrite) begin
      end_d = 1'b0;
    end
    both_d = (cnt_d == 16'h0000) && (ncnt_d == 16'h0000);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= `PTC_PTR_RESET;
      nptr_q <= `PTC_PTR_RESET;
      cnt_q <= `PTC_CNT_RESET;
      ncnt_q <= `PTC_CNT_RESET;
      en_q <= 1'b0;
      end_q <= 1'b0;
      both_q <= 1'b1;
    end else if (ce) begin
      ptr_q <= ptr_d;
      nptr_q <= nptr_d;
      cnt_q <= cnt_d;
      ncnt_q <= ncnt_d;
      en_q <= en_d;
      end_q <= end_d;
      both_q <= both_d;
    end
  end

  assign trig = en_q && (cnt_q != 16'h0000);
  assign st = '{ptr: ptr_q, cnt: cnt_q, nptr: nptr_q, ncnt: ncnt_q,
                en: en_q, endFlag: end_q, bothFlag: both_q};

  AST_PTR_STEP: assert property (@(posedge clk) disable iff (!rstn || !ce)
    doStep && !chain && !wr.wrPtr |=> ptr_q == $past(ptr_q) + $past(stepInc))
    else $error("pointer did not advance by the transfer width");
  AST_CHAIN_LOAD: assert property (@(posedge clk) disable iff (!rstn || !ce)
    chain && !wr.wrCnt && !wr.wrPtr |=> cnt_q == $past(ncnt_q) && ptr_q == $past(nptr_q))
    else $error("next buffer was not chained into current");
  AST_NEXT_CLEAR: assert property (@(posedge clk) disable iff (!rstn || !ce)
    chain && !wr.wrNcnt |=> ncnt_q == 16'h0000)
    else $error("next count not cleared after chaining");
  AST_END_SET: assert property (@(posedge clk) disable iff (!rstn || !ce)
    hitZero |=> end_q)
    else $error("end flag not set when counter reached zero");
  AST_END_CLEAR: assert property (@(posedge clk) disable iff (!rstn || !ce)
    cntWrite && !hitZero |=> !end_q)
    else $error("end flag not cleared by counter write");
  AST_BOTH: assert property (@(posedge clk) disable iff (!rstn || !ce)
    both_q == ((cnt_q == 16'h0000) && (ncnt_q == 16'h0000)))
    else $error("both-buffers flag disagrees with counters");
  AST_DIS_WINS: assert property (@(posedge clk) disable iff (!rstn || !ce)
    wr.disCmd |=> !en_q)
    else $error("channel enabled despite disable command");
  AST_CNT_WRITE: assert property (@(posedge clk) disable iff (!rstn || !ce)
    wr.wrCnt |=> cnt_q == $past(wrCntVal))
    else $error("counter write not taken");
  AST_STOP: assert property (@(posedge clk) disable iff (!rstn || !ce)
    cnt_q == 16'h0000 |-> !trig)
    else $error("trigger active with empty counter");

endmodule : ptc_channel

// *** src/ptc_controller.sv ***
`include "ptc_params.svh"

// Contract
// - One receive and one transmit channel per peripheral.
// - Channel registers start at offset 0x100 in each peripheral space.
// - Four 32-bit pointers and four 16-bit counters per peripheral.
// - Reads return next transfer address and remaining transfer count.
// - Enable and disable commands per direction; enable state readable in status.
// - End-of-buffer flag sets when the current counter reaches zero.
// - Both-buffers flag set only when current and next counters are zero.
// - Pointer advances by one, two or four per transfer.
// - Pointer written during operation is used by later transfers.
// - Counter decrements per transfer; at zero channel stops and signals peripheral.
// - Both counters zero disables trigger and raises the both-buffers flag.
// - Counter written during operation continues counting from the written value.
// - At zero with nonzero next count, next pair loads into current.
// - Next counter is cleared once moved into the current counter.
// - Writing current or next counter clears the end flag; if the current counter reaches zero in the same cycle, the flag sets instead.
// - End and both-buffer flags reach peripheral status for interrupts.
// - Receive ready: take bus, read holding register, write memory.
// - Transmit ready: take bus, read memory, write peripheral transmit data.
// - Memory-to-peripheral one cycle; peripheral-to-memory two cycles.
// - Simultaneous same-direction requests ordered by peripheral number.
// - Receive requests are served before transmit requests.
// - Disable command wins over a simultaneous enable command.
module ptc_controller #(
  parameter int N = `PTC_NPERIPH,
  parameter int IW = (N > 1) ? $clog2(N) : 1,
  parameter int AW = `PTC_OFS_W + IW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [AW-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [N-1:0] periphRxReady,
  input wire logic [N-1:0] periphTxReady,
  input wire logic [N-1:0][31:0] periphRxHolding,
  input ptc_pkg::ptc_width_e [N-1:0] periphRxWidth,
  input ptc_pkg::ptc_width_e [N-1:0] periphTxWidth,
  output logic [N-1:0] rxHoldingRead,
  output logic [N-1:0] txDataWrite,
  output logic [31:0] txData,
  output logic [N-1:0] rxBufferEnd,
  output logic [N-1:0] txBufferEnd,
  output logic [N-1:0] rxBothFull,
  output logic [N-1:0] txBothEmpty,
  output logic busReq,
  input wire logic busGrant,
  output ptc_pkg::ptc_mem_s memOut,
  input wire logic [31:0] memRdata
);
  import ptc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire [IW-1:0] regIdx = regAddr[AW-1 -: IW];
  wire [`PTC_OFS_W-1:0] regOfs = regAddr[`PTC_OFS_W-1:0];
  wire idxOk = {1'b0, regIdx} < (IW + 1)'(N);

  ptc_state_e state_q, state_d;
  logic [IW-1:0] sel_q, sel_d;
  ptc_mem_s mem_q, mem_d;
  logic [31:0] txData_q, txData_d;
  logic [31:0] rdata_q, rdata_d;

  ptc_chan_s rxSt [N];
  ptc_chan_s txSt [N];
  ptc_chan_wr_s rxWr [N];
  ptc_chan_wr_s txWr [N];
  logic [31:0] rdWord [N];
  logic [N-1:0] rxTrig, txTrig, rxReq, txReq, rxStep, txStep;

  ////////////////////////////////////////////////////////////////////////////
  // Channel pairs.

  for (genvar g = 0; g < N; g++) begin : gPair
    wire selP = idxOk && (regIdx == IW'(g));
    wire wrP = regWr && selP;
    wire ctrlWr = wrP && (regOfs == `PTC_OFS_CTRL);
    wire selNow = (sel_q == IW'(g));

    assign rxWr[g] = '{wrPtr: wrP && (regOfs == `PTC_OFS_RX_PTR),
                       wrCnt: wrP && (regOfs == `PTC_OFS_RX_CNT),
                       wrNptr: wrP && (regOfs == `PTC_OFS_RX_NPTR),
                       wrNcnt: wrP && (regOfs == `PTC_OFS_RX_NCNT),
                       enCmd: ctrlWr && regWdata[`PTC_CTRL_RX_EN],
                       disCmd: ctrlWr && regWdata[`PTC_CTRL_RX_DIS],
                       data: regWdata};
    assign txWr[g] = '{wrPtr: wrP && (regOfs == `PTC_OFS_TX_PTR),
                       wrCnt: wrP && (regOfs == `PTC_OFS_TX_CNT),
                       wrNptr: wrP && (regOfs == `PTC_OFS_TX_NPTR),
                       wrNcnt: wrP && (regOfs == `PTC_OFS_TX_NCNT),
                       enCmd: ctrlWr && regWdata[`PTC_CTRL_TX_EN],
                       disCmd: ctrlWr && regWdata[`PTC_CTRL_TX_DIS],
                       data: regWdata};

    // The step lands in the cycle the memory side of the transfer happens.
    assign rxStep[g] = (state_q == PTC_RX_WRITE) && selNow;
    assign txStep[g] = (state_q == PTC_TX_READ) && selNow;

    ptc_channel uRx (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .wr(rxWr[g]),
      .step(rxStep[g]),
      .width(periphRxWidth[g]),
      .st(rxSt[g]),
      .trig(rxTrig[g])
    );

    ptc_channel uTx (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .wr(txWr[g]),
      .step(txStep[g]),
      .width(periphTxWidth[g]),
      .st(txSt[g]),
      .trig(txTrig[g])
    );

    assign rxReq[g] = periphRxReady[g] && rxTrig[g];
    assign txReq[g] = periphTxReady[g] && txTrig[g];

    assign rxBufferEnd[g] = rxSt[g].endFlag;
    assign txBufferEnd[g] = txSt[g].endFlag;
    assign rxBothFull[g] = rxSt[g].bothFlag;
    assign txBothEmpty[g] = txSt[g].bothFlag;

    wire [31:0] statWord = {12'h000, txSt[g].bothFlag, rxSt[g].bothFlag,
                            txSt[g].endFlag, rxSt[g].endFlag, 7'h00, txSt[g].en,
                            7'h00, rxSt[g].en};
    assign rdWord[g] =
      (regOfs == `PTC_OFS_RX_PTR) ? rxSt[g].ptr :
      (regOfs == `PTC_OFS_RX_CNT) ? {16'h0000, rxSt[g].cnt} :
      (regOfs == `PTC_OFS_TX_PTR) ? txSt[g].ptr :
      (regOfs == `PTC_OFS_TX_CNT) ? {16'h0000, txSt[g].cnt} :
      (regOfs == `PTC_OFS_RX_NPTR) ? rxSt[g].nptr :
      (regOfs == `PTC_OFS_RX_NCNT) ? {16'h0000, rxSt[g].ncnt} :
      (regOfs == `PTC_OFS_TX_NPTR) ? txSt[g].nptr :
      (regOfs == `PTC_OFS_TX_NCNT) ? {16'h0000, txSt[g].ncnt} :
      (regOfs == `PTC_OFS_STAT) ? statWord : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request selection.

  logic rxAny, txAny;
  logic [IW-1:0] rxIdx, txIdx;

  ptc_pick #(.N(N), .IW(IW)) uRxPick (
    .req(rxReq),
    .any(rxAny),
    .idx(rxIdx)
  );

  ptc_pick #(.N(N), .IW(IW)) uTxPick (
    .req(txReq),
    .any(txAny),
    .idx(txIdx)
  );

  wire inIdle = (state_q == PTC_IDLE);
  wire rxGo = inIdle && busGrant && rxAny;
  wire txGo = inIdle && busGrant && !rxAny && txAny;
  wire [31:0] holdSel = periphRxHolding[sel_q];

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    mem_d = mem_q;
    mem_d.wr = 1'b0;
    mem_d.rd = 1'b0;
    txData_d = txData_q;
    unique case (state_q)
      PTC_IDLE: begin
        if (rxGo) begin
          state_d = PTC_RX_READ;
          sel_d = rxIdx;
        end else if (txGo) begin
          state_d = PTC_TX_READ;
          sel_d = txIdx;
          mem_d.addr = txSt[txIdx].ptr;
          mem_d.size = periphTxWidth[txIdx];
          mem_d.rd = 1'b1;
        end
      end
      PTC_RX_READ: begin
        state_d = PTC_RX_WRITE;
        mem_d.addr = rxSt[sel_q].ptr;
        mem_d.wdata = holdSel;
        mem_d.size = periphRxWidth[sel_q];
        mem_d.wr = 1'b1;
      end
      PTC_RX_WRITE: begin
        state_d = PTC_IDLE;
      end
      PTC_TX_READ: begin
        state_d = PTC_TX_PUSH;
        txData_d = memRdata;
      end
      PTC_TX_PUSH: begin
        state_d = PTC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= PTC_IDLE;
      sel_q <= '0;
      mem_q <= '0;
      txData_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      state_q <= state_d;
      sel_q <= sel_d;
      mem_q <= mem_d;
      txData_q <= txData_d;
      rdata_q <= rdata_d;
    end
  end

  // Unmapped peripheral slots and offsets read as zero.
  assign rdata_d = (regRd && idxOk) ? rdWord[regIdx] : 32'h0000_0000;
  assign regRdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // bus held one or two cycles.
  assign busReq = (inIdle && (rxAny || txAny)) || (state_q == PTC_RX_READ)
                  || (state_q == PTC_RX_WRITE) || (state_q == PTC_TX_READ);
  assign memOut = mem_q;
  assign txData = txData_q;
  assign rxHoldingRead = (state_q == PTC_RX_READ) ? (N'(1) << sel_q) : '0;
  assign txDataWrite = (state_q == PTC_TX_PUSH) ? (N'(1) << sel_q) : '0;

  AST_RX_SEQ: assert property (@(posedge clk) disable iff (!rstn || !ce)
    rxGo |=> (state_q == PTC_RX_READ && rxHoldingRead != '0)
    ##1 (state_q == PTC_RX_WRITE && memOut.wr && memOut.wdata == $past(holdSel)))
    else $error("receive sequence did not read holding then write memory");
  AST_TX_SEQ: assert property (@(posedge clk) disable iff (!rstn || !ce)
    state_q == PTC_TX_READ |-> memOut.rd && busReq
    ##1 (txDataWrite != '0 && txData == $past(memRdata)))
    else $error("transmit data not taken from memory read");
  AST_RX_TWO: assert property (@(posedge clk) disable iff (!rstn || !ce)
    state_q == PTC_RX_READ |=> state_q == PTC_RX_WRITE ##1 state_q == PTC_IDLE)
    else $error("receive transfer not two bus cycles");
  AST_RX_FIRST: assert property (@(posedge clk) disable iff (!rstn || !ce)
    inIdle && busGrant && rxAny && txAny |=> state_q == PTC_RX_READ)
    else $error("transmit served ahead of pending receive");
  AST_LOW_FIRST: assert property (@(posedge clk) disable iff (!rstn || !ce)
    inIdle && busGrant && rxReq[0] |=> sel_q == '0)
    else $error("lower peripheral number not served first");

endmodule : ptc_controller

// *** testbench/ptc_far_model.sv ***
module ptc_far_model #(
  parameter int N = 2,
  parameter logic [31:0] MEM_KEY = 32'h5A3C_96E1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [N-1:0] rxHoldingRead,
  input wire logic [N-1:0] txDataWrite,
  input wire logic busReq,
  input ptc_pkg::ptc_mem_s memOut,
  output logic [N-1:0] periphRxReady,
  output logic [N-1:0] periphTxReady,
  output logic [N-1:0][31:0] periphRxHolding,
  output ptc_pkg::ptc_width_e [N-1:0] periphRxWidth,
  output ptc_pkg::ptc_width_e [N-1:0] periphTxWidth,
  output logic busGrant,
  output logic [31:0] memRdata
);
  import ptc_pkg::*;

  int grantDelay = 0;
  int waitCnt = 0;

  initial begin
    periphRxReady = '0;
    periphTxReady = '0;
    periphRxHolding = '0;
    for (int i = 0; i < N; i++) begin
      periphRxWidth[i] = PTC_BYTE;
      periphTxWidth[i] = PTC_BYTE;
    end
  end

  ////////////////////////////////////////
  // grant after delay.
  // The arbiter may keep the controller waiting; once given, the grant stays while requested.
  always @(posedge clk or negedge rstn) begin
    if (!rstn || !busReq) begin
      busGrant <= 1'b0;
      waitCnt <= 0;
    end else if (waitCnt >= grantDelay) begin
      busGrant <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 1;
    end
  end

  // memory read data.
  // Outside a read the data lines show the inverse, so stale data cannot pass for fresh.
  assign memRdata = memOut.rd ? memOut.addr ^ MEM_KEY : ~(memOut.addr ^ MEM_KEY);

  ////////////////////////////////////////
  // ready drops when served.
  always @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (rxHoldingRead[i]) begin
        periphRxReady[i] <= 1'b0;
        periphRxHolding[i] <= ~periphRxHolding[i];
      end
      if (txDataWrite[i]) begin
        periphTxReady[i] <= 1'b0;
      end
    end
  end

  task automatic raise(input logic tx, input int i, input logic [31:0] d);
    if (tx) begin
      periphTxReady[i] <= 1'b1;
    end else begin
      periphRxReady[i] <= 1'b1;
      periphRxHolding[i] <= d;
    end
  endtask : raise
endmodule : ptc_far_model

// *** testbench/tb_top.sv ***
`include "ptc_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ptc_pkg::*;

  localparam logic [31:0] KEY = 32'h5A3C_96E1;

  logic clk;
  logic rstn;
  logic ce;
  logic [9:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic [1:0] periphRxReady;
  logic [1:0] periphTxReady;
  logic [1:0][31:0] periphRxHolding;
  ptc_width_e [1:0] periphRxWidth;
  ptc_width_e [1:0] periphTxWidth;
  logic [1:0] rxHoldingRead;
  logic [1:0] txDataWrite;
  logic [31:0] txData;
  logic [1:0] rxBufferEnd;
  logic [1:0] txBufferEnd;
  logic [1:0] rxBothFull;
  logic [1:0] txBothEmpty;
  logic busReq;
  logic busGrant;
  ptc_mem_s memOut;
  logic [31:0] memRdata;
  logic [66:0] evq[$];
  logic [66:0] rdq[$];
  logic rdSeen = 1'b0;
  logic holdSeen = 1'b0;
  logic rdMemSeen = 1'b0;
  int n_fail = 0;
  int check_count = 0;

  ptc_controller #(.N(2)) ptc_controller_i (
    .clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .periphRxReady(periphRxReady),
    .periphTxReady(periphTxReady), .periphRxHolding(periphRxHolding),
    .periphRxWidth(periphRxWidth), .periphTxWidth(periphTxWidth),
    .rxHoldingRead(rxHoldingRead), .txDataWrite(txDataWrite), .txData(txData),
    .rxBufferEnd(rxBufferEnd), .txBufferEnd(txBufferEnd), .rxBothFull(rxBothFull),
    .txBothEmpty(txBothEmpty), .busReq(busReq), .busGrant(busGrant), .memOut(memOut),
    .memRdata(memRdata));

  ptc_far_model #(.N(2), .MEM_KEY(KEY)) far_i (
    .clk(clk), .rstn(rstn), .rxHoldingRead(rxHoldingRead), .txDataWrite(txDataWrite),
    .busReq(busReq), .memOut(memOut), .periphRxReady(periphRxReady),
    .periphTxReady(periphTxReady), .periphRxHolding(periphRxHolding),
    .periphRxWidth(periphRxWidth), .periphTxWidth(periphTxWidth), .busGrant(busGrant),
    .memRdata(memRdata));

  always #12.5 clk = ~clk;

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [66:0] seen, input logic [66:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // An empty queue yields a note that no real result can match.
  function automatic logic [66:0] take(ref logic [66:0] q[$]);
    if (q.size() == 0) return '1;
    return q.pop_front();
  endfunction : take

  always @(posedge clk) begin
    if (rdSeen) chk("regRdata", 67'(regRdata), take(rdq));
    if (memOut.wr) chk("memWrite", {1'b0, memOut.size, memOut.addr, memOut.wdata}, take(evq));
    if (memOut.wr) chk("rxTwoCycles", 67'(holdSeen), 67'(1));
    if (|txDataWrite) chk("txPush", {1'b1, txDataWrite, 32'h0, txData}, take(evq));
    if (|txDataWrite) chk("txOneCycle", 67'(rdMemSeen), 67'(1));
    rdSeen = regRd;
    holdSeen = |rxHoldingRead;
    rdMemSeen = memOut.rd;
  end

  task automatic wr(input int p, input logic [8:0] o, input logic [31:0] d);
    @(posedge clk);
    regAddr <= {p[0], o};
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input int p, input logic [8:0] o, input logic [31:0] e);
    @(posedge clk);
    regAddr <= {p[0], o};
    regRd <= 1'b1;
    rdq.push_back(67'(e));
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd

  task automatic drain();
    for (int k = 0; k < 40 && evq.size() > 0; k++) @(posedge clk);
    chk("queueEmpty", 67'(evq.size()), 67'(0));
    repeat (2) @(posedge clk);
  endtask : drain

  task automatic rx(input int p, input logic [31:0] d);
    @(posedge clk);
    far_i.raise(1'b0, p, d);
    drain();
  endtask : rx

  // Two buffers chained, then a request that must be left waiting.
  task automatic rxRun(input int p, input int w);
    logic [31:0] base;
    logic [31:0] nb;
    logic [31:0] d;
    base = $urandom & 32'hFFFF_FFFC;
    nb = $urandom & 32'hFFFF_FFFC;
    far_i.grantDelay <= w;
    far_i.periphRxWidth[p] <= ptc_width_e'(w);
    wr(p, `PTC_OFS_RX_PTR, base);
    wr(p, `PTC_OFS_RX_CNT, 32'h2);
    wr(p, `PTC_OFS_RX_NPTR, nb);
    wr(p, `PTC_OFS_RX_NCNT, 32'h1);
    wr(p, `PTC_OFS_CTRL, 32'h1);
    rd(p, `PTC_OFS_STAT, 32'h0008_0001);
    for (int k = 0; k < 3; k++) begin
      d = $urandom;
      evq.push_back({1'b0, 2'(w), (k == 2) ? nb : base + 32'(k << w), d});
      rx(p, d);
      if (k == 0) rd(p, `PTC_OFS_RX_PTR, base + (32'h1 << w));
      if (k == 0) rd(p, `PTC_OFS_RX_CNT, 32'h1);
      if (k == 1) rd(p, `PTC_OFS_RX_NCNT, 32'h0);
      if (k == 1) rd(p, `PTC_OFS_STAT, 32'h0009_0001);
    end
    rd(p, `PTC_OFS_STAT, 32'h000D_0001);
    @(posedge clk);
    far_i.raise(1'b0, p, $urandom);
    repeat (8) @(posedge clk);
    chk("busReq", 67'(busReq), 67'(0));
    far_i.periphRxReady[p] <= 1'b0;
    wr(p, `PTC_OFS_RX_CNT, 32'h0);
    rd(p, `PTC_OFS_STAT, 32'h000C_0001);
    wr(p, `PTC_OFS_CTRL, 32'h2);
  endtask : rxRun

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end

  ////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] d0;
    logic [31:0] d1;
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    regAddr = '0;
    regWdata = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    void'($urandom(66994));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wr(p, 9'h000, 32'hFFFF_FFFF);
      for (int o = 'h100; o < 'h120; o += 4) rd(p, 9'(o), 32'h0);
      rd(p, `PTC_OFS_STAT, 32'h000C_0000);
      rd(p, 9'h128, 32'h0);
      for (int o = 'h100; o < 'h120; o += 4) begin
        v = $urandom;
        wr(p, 9'(o), v);
        rd(p, 9'(o), o[2] ? {16'h0, v[15:0]} : v);
        if (o[2]) wr(p, 9'(o), 32'h0);
      end
    end
    for (int w = 0; w < 3; w++) rxRun(w % 2, w);
    a = $urandom & 32'hFFFF_FFFC;
    b = $urandom & 32'hFFFF_FFFC;
    d0 = $urandom;
    far_i.periphRxWidth[1] <= PTC_WORD;
    wr(1, `PTC_OFS_RX_PTR, a);
    wr(1, `PTC_OFS_RX_CNT, 32'h5);
    wr(1, `PTC_OFS_CTRL, 32'h1);
    evq.push_back({1'b0, 2'd2, a, d0});
    rx(1, d0);
    wr(1, `PTC_OFS_RX_PTR, b);
    wr(1, `PTC_OFS_RX_CNT, 32'h1);
    evq.push_back({1'b0, 2'd2, b, ~d0});
    rx(1, ~d0);
    rd(1, `PTC_OFS_RX_CNT, 32'h0);
    rd(1, `PTC_OFS_RX_PTR, b + 32'h4);
    a = $urandom & 32'hFFFF_FFFC;
    b = $urandom & 32'hFFFF_FFFC;
    v = $urandom & 32'hFFFF_FFFC;
    d0 = $urandom;
    d1 = $urandom;
    far_i.grantDelay <= 0;
    far_i.periphTxWidth[0] <= PTC_WORD;
    wr(0, `PTC_OFS_RX_PTR, a);
    wr(0, `PTC_OFS_RX_CNT, 32'h1);
    wr(1, `PTC_OFS_RX_PTR, b);
    wr(1, `PTC_OFS_RX_CNT, 32'h1);
    wr(0, `PTC_OFS_TX_PTR, v);
    wr(0, `PTC_OFS_TX_CNT, 32'h1);
    wr(0, `PTC_OFS_CTRL, 32'h101);
    wr(1, `PTC_OFS_CTRL, 32'h1);
    evq.push_back({1'b0, 2'd2, a, d0});
    evq.push_back({1'b0, 2'd2, b, d1});
    evq.push_back({1'b1, 2'b01, 32'h0, v ^ KEY});
    @(posedge clk);
    far_i.raise(1'b1, 0, 32'h0);
    far_i.raise(1'b0, 1, d1);
    far_i.raise(1'b0, 0, d0);
    drain();
    chk("flags", 67'({rxBufferEnd, txBufferEnd, rxBothFull, txBothEmpty}), 67'(8'hDF));
    rd(0, `PTC_OFS_STAT, 32'h000F_0101);
    wr(0, `PTC_OFS_CTRL, 32'h303);
    rd(0, `PTC_OFS_STAT, 32'h000F_0000);
    wr(0, `PTC_OFS_RX_CNT, 32'h1);
    rd(0, `PTC_OFS_STAT, 32'h000A_0000);
    @(posedge clk);
    far_i.raise(1'b0, 0, d1);
    repeat (8) @(posedge clk);
    chk("busReq", 67'(busReq), 67'(0));
    evq.push_back({1'b0, 2'd2, a + 32'h4, d1});
    // A counter write while the clock enable is low must be lost, or no transfer follows.
    @(posedge clk);
    ce <= 1'b0;
    wr(0, `PTC_OFS_RX_CNT, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    wr(0, `PTC_OFS_CTRL, 32'h1);
    drain();
    wrap_up();
  end
endmodule : tb_top
